// File: common/ips_defines.svh
// Offsets, field positions, reset values of the pending-summary block.
// Assumes a 4-bit register address and 8-bit register data.
`ifndef IPS_DEFINES_SVH
`define IPS_DEFINES_SVH

// Register offsets
`define IPS_OFS_SUMMARY 4'h0
`define IPS_OFS_WAKEUP_CTRL 4'h1
`define IPS_OFS_EVENT_STATUS 4'h2
`define IPS_OFS_EVENT_MASK 4'h3
`define IPS_OFS_TIMER_DETAIL 4'h4

// Summary bit positions
`define IPS_BIT_TWO_WIRE 7
`define IPS_BIT_KEYPAD 6
`define IPS_BIT_COMPARATOR 5
`define IPS_BIT_CONVERTER 4
`define IPS_BIT_TIMER_PWM 3
`define IPS_BIT_MODULO_TWO 2
`define IPS_BIT_MODULO_ONE 1
`define IPS_BIT_WAKEUP 0

// Periodic wakeup status/control fields
`define IPS_WK_FLAG_BIT 7
`define IPS_WK_ACK_BIT 6
`define IPS_WK_CLKSEL_BIT 5
`define IPS_WK_IRQEN_BIT 4
`define IPS_WK_DELAY_HI 2
`define IPS_WK_DELAY_LO 0

// Timer detail fields
`define IPS_TD_OVERFLOW_BIT 0
`define IPS_TD_CHANNEL0_BIT 1
`define IPS_TD_CHANNEL1_BIT 2

// Reset values
`define IPS_RST_SUMMARY 8'h00
`define IPS_RST_MASK 8'h00
`define IPS_RST_DELAY 3'h0
`define IPS_RST_RDATA 8'h00

`endif

// File: common/ips_pkg.sv
// Types shared by the pending-summary block.
// Assumes ips_defines.svh carries the numeric constants.
package ips_pkg;

	typedef logic [7:0] ips_byte_t;
	typedef logic [3:0] ips_addr_t;
	typedef logic [2:0] ips_delay_t;

endpackage

// File: hw/ips_pending_summary.sv
// Interrupt pending summary: one read-only byte of source request terms,
// plus the periodic wakeup flag/control, event status, mask and irq line.
// Assumes all source flags and enables are levels on CORE_CLK.
// Function
// RULE1: Eight-bit readable summary, one bit per on-chip source with pending request.
// RULE2: Bit 7 is two-wire flag AND enable; clears with the flag.
// RULE3: Bit 6 is keypad flag AND enable; clears with the flag.
// RULE4: Bit 5 is comparator flag AND enable; clears with the flag.
// RULE5: Bit 4 is conversion-done flag AND enable; clears with the flag.
// RULE6: Bit 3 ORs overflow, channel 0 and channel 1 flag/enable pairs.
// RULE7: Bit 3 clears once no enabled timer/PWM flag term remains.
// RULE8: Bit 2 is second modulo timer overflow flag AND enable.
// RULE9: Bit 1 is first modulo timer overflow flag AND enable.
// RULE10: Bit 0 is periodic wakeup flag AND enable; clears with flag.
// RULE11: All summary bits read zero right after any reset.
// RULE12: Writing one to wakeup acknowledge clears its flag; zero does nothing.
// RULE13: Writes to the summary are ignored; only terms or reset change it.
`include "ips_defines.svh"
`timescale 1ns/1ps

module ips_pending_summary
	import ips_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic TWO_WIRE_EVENT_FLAG,
	input wire logic TWO_WIRE_IRQ_ENABLE,
	input wire logic KEYPAD_EVENT_FLAG,
	input wire logic KEYPAD_IRQ_ENABLE,
	input wire logic COMPARATOR_EVENT_FLAG,
	input wire logic COMPARATOR_IRQ_ENABLE,
	input wire logic CONVERSION_DONE_FLAG,
	input wire logic CONVERTER_IRQ_ENABLE,
	input wire logic OVERFLOW_FLAG,
	input wire logic OVERFLOW_IRQ_ENABLE,
	input wire logic CHANNEL0_EVENT_FLAG,
	input wire logic CHANNEL0_IRQ_ENABLE,
	input wire logic CHANNEL1_EVENT_FLAG,
	input wire logic CHANNEL1_IRQ_ENABLE,
	input wire logic MODULO_TIMER_TWO_OVERFLOW_FLAG,
	input wire logic MODULO_TIMER_TWO_IRQ_ENABLE,
	input wire logic MODULO_TIMER_ONE_OVERFLOW_FLAG,
	input wire logic MODULO_TIMER_ONE_IRQ_ENABLE,
	input wire logic PERIODIC_WAKEUP_TIMEOUT,
	output logic PERIODIC_WAKEUP_FLAG,
	output logic PERIODIC_WAKEUP_IRQ_ENABLE,
	output logic PERIODIC_WAKEUP_CLOCK_SELECT,
	output logic [2:0] PERIODIC_WAKEUP_DELAY_SELECT,
	output logic [7:0] INTERRUPT_PENDING_SUMMARY,
	output logic IRQ
);

	// A source requests only while flag and enable are both high
	function automatic logic pair_pending(input logic flag, input logic enable);
		pair_pending = flag & enable;
	endfunction

	// Full compare: unmapped offsets select nothing and read zero
	function automatic logic hit(input ips_addr_t addr, input ips_addr_t offset);
		hit = (addr == offset);
	endfunction

	// Gate a register view onto the read bus when its offset is selected
	function automatic ips_byte_t view_if(input logic sel, input ips_byte_t value);
		view_if = sel ? value : 8'h00;
	endfunction

	// Bus decode
	logic sel_summary;
	logic sel_wakeup;
	logic sel_status;
	logic sel_mask;
	logic sel_detail;
	logic wr_wakeup;
	logic wr_status;
	logic wr_mask;

	assign sel_summary = hit(REG_ADDR, `IPS_OFS_SUMMARY);
	assign sel_wakeup = hit(REG_ADDR, `IPS_OFS_WAKEUP_CTRL);
	assign sel_status = hit(REG_ADDR, `IPS_OFS_EVENT_STATUS);
	assign sel_mask = hit(REG_ADDR, `IPS_OFS_EVENT_MASK);
	assign sel_detail = hit(REG_ADDR, `IPS_OFS_TIMER_DETAIL);
	// No write path exists into the summary byte [RULE13]
	assign wr_wakeup = REG_WR & sel_wakeup;
	assign wr_status = REG_WR & sel_status;
	assign wr_mask = REG_WR & sel_mask;

	// Periodic wakeup flag and control
	logic wakeup_ack;
	logic wakeup_flag;
	logic wakeup_irq_enable;
	logic wakeup_clock_select;
	ips_delay_t wakeup_delay;

	// Only a one on the acknowledge bit clears; a zero is inert [RULE12]
	assign wakeup_ack = wr_wakeup & REG_WDATA[`IPS_WK_ACK_BIT];

	// Timeout pulse of any length sets; set wins over a same-cycle acknowledge
	ips_sticky_bit u_wakeup_flag (
		.clk(CORE_CLK),
		.rst(RST),
		.set(PERIODIC_WAKEUP_TIMEOUT),
		.clear(wakeup_ack),
		.q(wakeup_flag)
	);

	// Control fields are plain storage; the wakeup timer itself sits outside
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wakeup_irq_enable <= 1'b0;
		end else if (wr_wakeup) begin
			wakeup_irq_enable <= REG_WDATA[`IPS_WK_IRQEN_BIT];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wakeup_clock_select <= 1'b0;
		end else if (wr_wakeup) begin
			wakeup_clock_select <= REG_WDATA[`IPS_WK_CLKSEL_BIT];
		end
	end

	// Delay code zero stops the timer outside, so reset leaves it idle
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wakeup_delay <= `IPS_RST_DELAY;
		end else if (wr_wakeup) begin
			wakeup_delay <= REG_WDATA[`IPS_WK_DELAY_HI:`IPS_WK_DELAY_LO];
		end
	end

	assign PERIODIC_WAKEUP_FLAG = wakeup_flag;
	assign PERIODIC_WAKEUP_IRQ_ENABLE = wakeup_irq_enable;
	assign PERIODIC_WAKEUP_CLOCK_SELECT = wakeup_clock_select;
	assign PERIODIC_WAKEUP_DELAY_SELECT = wakeup_delay;

	// Timer/PWM contributors kept apart so software can see which one fired
	logic term_overflow;
	logic term_channel0;
	logic term_channel1;
	logic term_timer_pwm;

	assign term_overflow = pair_pending(OVERFLOW_FLAG, OVERFLOW_IRQ_ENABLE); // [RULE6]
	assign term_channel0 = pair_pending(CHANNEL0_EVENT_FLAG, CHANNEL0_IRQ_ENABLE); // [RULE6]
	assign term_channel1 = pair_pending(CHANNEL1_EVENT_FLAG, CHANNEL1_IRQ_ENABLE); // [RULE6]
	// Drops only when every enabled term has gone [RULE7]
	assign term_timer_pwm = term_overflow | term_channel0 | term_channel1;

	// One named request term per summary bit
	logic pend_two_wire;
	logic pend_keypad;
	logic pend_comparator;
	logic pend_converter;
	logic pend_timer_pwm;
	logic pend_modulo_two;
	logic pend_modulo_one;
	logic pend_wakeup;

	assign pend_two_wire =
		pair_pending(TWO_WIRE_EVENT_FLAG, TWO_WIRE_IRQ_ENABLE); // [RULE2]
	assign pend_keypad =
		pair_pending(KEYPAD_EVENT_FLAG, KEYPAD_IRQ_ENABLE); // [RULE3]
	assign pend_comparator =
		pair_pending(COMPARATOR_EVENT_FLAG, COMPARATOR_IRQ_ENABLE); // [RULE4]
	assign pend_converter =
		pair_pending(CONVERSION_DONE_FLAG, CONVERTER_IRQ_ENABLE); // [RULE5]
	assign pend_timer_pwm = term_timer_pwm; // [RULE6] [RULE7]
	assign pend_modulo_two =
		pair_pending(MODULO_TIMER_TWO_OVERFLOW_FLAG, MODULO_TIMER_TWO_IRQ_ENABLE); // [RULE8]
	assign pend_modulo_one =
		pair_pending(MODULO_TIMER_ONE_OVERFLOW_FLAG, MODULO_TIMER_ONE_IRQ_ENABLE); // [RULE9]
	// Enable and flag are both needed before the wakeup bit rises
	assign pend_wakeup =
		pair_pending(wakeup_flag, wakeup_irq_enable); // [RULE10]

	// Next summary value, one term per bit
	ips_byte_t next_summary;

	assign next_summary[`IPS_BIT_TWO_WIRE] = pend_two_wire;
	assign next_summary[`IPS_BIT_KEYPAD] = pend_keypad;
	assign next_summary[`IPS_BIT_COMPARATOR] = pend_comparator;
	assign next_summary[`IPS_BIT_CONVERTER] = pend_converter;
	assign next_summary[`IPS_BIT_TIMER_PWM] = pend_timer_pwm;
	assign next_summary[`IPS_BIT_MODULO_TWO] = pend_modulo_two;
	assign next_summary[`IPS_BIT_MODULO_ONE] = pend_modulo_one;
	assign next_summary[`IPS_BIT_WAKEUP] = pend_wakeup;

	// Registered so reset forces zero whatever the sources hold
	ips_byte_t summary;
	ips_byte_t summary_prev;

	// Reads see the registered byte, never a glitching AND term
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			summary <= `IPS_RST_SUMMARY; // [RULE11]
		end else begin
			summary <= next_summary; // [RULE1] [RULE13]
		end
	end

	// Zero after reset, so a term already high gives one clean event edge
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			summary_prev <= `IPS_RST_SUMMARY;
		end else begin
			summary_prev <= summary;
		end
	end

	// Pin view and register view are the same flops
	assign INTERRUPT_PENDING_SUMMARY = summary;

	// Event status: a rising summary bit is one event
	ips_byte_t rise;
	ips_byte_t status_clear;
	ips_byte_t event_status;
	ips_byte_t event_mask;

	assign rise = summary & ~summary_prev;
	// Write-one-to-clear; zeros in the data leave bits alone
	assign status_clear = wr_status ? REG_WDATA : 8'h00;

	// One sticky status bit per summary bit; set beats a same-cycle clear
	ips_sticky_bit u_status_two_wire (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_TWO_WIRE]),
		.clear(status_clear[`IPS_BIT_TWO_WIRE]),
		.q(event_status[`IPS_BIT_TWO_WIRE])
	);

	ips_sticky_bit u_status_keypad (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_KEYPAD]),
		.clear(status_clear[`IPS_BIT_KEYPAD]),
		.q(event_status[`IPS_BIT_KEYPAD])
	);

	ips_sticky_bit u_status_comparator (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_COMPARATOR]),
		.clear(status_clear[`IPS_BIT_COMPARATOR]),
		.q(event_status[`IPS_BIT_COMPARATOR])
	);

	ips_sticky_bit u_status_converter (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_CONVERTER]),
		.clear(status_clear[`IPS_BIT_CONVERTER]),
		.q(event_status[`IPS_BIT_CONVERTER])
	);

	ips_sticky_bit u_status_timer_pwm (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_TIMER_PWM]),
		.clear(status_clear[`IPS_BIT_TIMER_PWM]),
		.q(event_status[`IPS_BIT_TIMER_PWM])
	);

	ips_sticky_bit u_status_modulo_two (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_MODULO_TWO]),
		.clear(status_clear[`IPS_BIT_MODULO_TWO]),
		.q(event_status[`IPS_BIT_MODULO_TWO])
	);

	ips_sticky_bit u_status_modulo_one (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_MODULO_ONE]),
		.clear(status_clear[`IPS_BIT_MODULO_ONE]),
		.q(event_status[`IPS_BIT_MODULO_ONE])
	);

	ips_sticky_bit u_status_wakeup (
		.clk(CORE_CLK),
		.rst(RST),
		.set(rise[`IPS_BIT_WAKEUP]),
		.clear(status_clear[`IPS_BIT_WAKEUP]),
		.q(event_status[`IPS_BIT_WAKEUP])
	);

	// Mask resets to zero so nothing interrupts until software opts in
	ips_byte_t next_mask;

	assign next_mask = wr_mask ? REG_WDATA : event_mask;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			event_mask <= `IPS_RST_MASK;
		end else begin
			event_mask <= next_mask;
		end
	end

	// Level output; stays up until every unmasked event is cleared
	assign IRQ = |(event_status & event_mask);

	// Read views
	ips_byte_t wakeup_view;
	ips_byte_t detail_view;
	ips_byte_t read_value;

	// Acknowledge bit always reads zero; bit 3 is unused
	assign wakeup_view = {wakeup_flag, 1'b0, wakeup_clock_select,
		wakeup_irq_enable, 1'b0, wakeup_delay};
	assign detail_view = {5'h00, term_channel1, term_channel0, term_overflow};

	// Offsets decode one-hot, so the gated views simply OR together
	assign read_value = view_if(sel_summary, summary)
		| view_if(sel_wakeup, wakeup_view)
		| view_if(sel_status, event_status)
		| view_if(sel_mask, event_mask)
		| view_if(sel_detail, detail_view);

	// Read data stand only in the cycle after the strobe
	// Zero between reads keeps a stale byte off the bus
	ips_byte_t next_rdata;

	assign next_rdata = REG_RD ? read_value : `IPS_RST_RDATA;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			REG_RDATA <= `IPS_RST_RDATA;
		end else begin
			REG_RDATA <= next_rdata;
		end
	end

endmodule

// File: hw/ips_sticky_bit.sv
// One sticky flag: set by a hardware event, cleared by a request.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps

module ips_sticky_bit
	import ips_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic set,
	input wire logic clear,
	output logic q
);

	// Set beats clear so an event in the clearing cycle survives
	logic next_q;

	assign next_q = set | (q & ~clear);

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

endmodule

// File: testbench/ips_pending_summary_bench.sv
// Bench: sources through the model, registers through the strobe port.
// Assumes design, model and checker compiled before it.
`timescale 1ns/1ps

module ips_pending_summary_bench
	import ips_pkg::*;
();
	logic CORE_CLK, RST, REG_WR, REG_RD, PERIODIC_WAKEUP_TIMEOUT, IRQ;
	logic PERIODIC_WAKEUP_FLAG, PERIODIC_WAKEUP_IRQ_ENABLE, PERIODIC_WAKEUP_CLOCK_SELECT;
	logic [2:0] PERIODIC_WAKEUP_DELAY_SELECT;
	ips_addr_t REG_ADDR;
	ips_byte_t REG_WDATA, REG_RDATA, INTERRUPT_PENDING_SUMMARY, v;
	logic [8:0] set_ev, clr_ev, src_en;
	wire [8:0] flag, ena;
	int n_errors, cmp_count, i;
	int bp [9] = '{1, 2, 3, 3, 3, 4, 5, 6, 7};
	ips_source_model src (.*);
	ips_pending_summary DUT (.*,
		.TWO_WIRE_EVENT_FLAG(flag[8]), .TWO_WIRE_IRQ_ENABLE(ena[8]),
		.KEYPAD_EVENT_FLAG(flag[7]), .KEYPAD_IRQ_ENABLE(ena[7]),
		.COMPARATOR_EVENT_FLAG(flag[6]), .COMPARATOR_IRQ_ENABLE(ena[6]),
		.CONVERSION_DONE_FLAG(flag[5]), .CONVERTER_IRQ_ENABLE(ena[5]),
		.OVERFLOW_FLAG(flag[4]), .OVERFLOW_IRQ_ENABLE(ena[4]),
		.CHANNEL0_EVENT_FLAG(flag[3]), .CHANNEL0_IRQ_ENABLE(ena[3]),
		.CHANNEL1_EVENT_FLAG(flag[2]), .CHANNEL1_IRQ_ENABLE(ena[2]),
		.MODULO_TIMER_TWO_OVERFLOW_FLAG(flag[1]), .MODULO_TIMER_TWO_IRQ_ENABLE(ena[1]),
		.MODULO_TIMER_ONE_OVERFLOW_FLAG(flag[0]), .MODULO_TIMER_ONE_IRQ_ENABLE(ena[0]));
	task chk(input ips_byte_t got, input ips_byte_t exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input ips_addr_t a, input ips_byte_t d);
		@(posedge CORE_CLK);
		REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask
	task rd(input ips_addr_t a, output ips_byte_t d);
		@(posedge CORE_CLK);
		REG_RD <= 1'b1; REG_ADDR <= a;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask
	// Pulse set/clear, hold the enables, then wait out flag plus summary register
	task srcs(input logic [8:0] s, input logic [8:0] c, input logic [8:0] e);
		@(posedge CORE_CLK);
		set_ev <= s; clr_ev <= c; src_en <= e;
		@(posedge CORE_CLK);
		set_ev <= 9'h000; clr_ev <= 9'h000;
		repeat (2) @(posedge CORE_CLK);
		#1;
	endtask
	task results;
		$display("errors %0d, compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		#200000;
		n_errors++;
		results();
	end
	initial begin
		RST = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 4'h0; REG_WDATA = 8'h00;
		PERIODIC_WAKEUP_TIMEOUT = 1'b0; set_ev = 9'h000; clr_ev = 9'h000; src_en = 9'h000;
		repeat (4) @(posedge CORE_CLK);
		RST <= 1'b0;
		rd(4'h0, v); chk(v, 8'h00);
		rd(4'h1, v); chk(v, 8'h00);
		for (i = 0; i < 9; i++) begin
			srcs(9'h001 << i, 9'h000, 9'h000); chk(INTERRUPT_PENDING_SUMMARY, 8'h00);
			srcs(9'h000, 9'h000, 9'h001 << i); chk(INTERRUPT_PENDING_SUMMARY, 8'h01 << bp[i]);
			wr(4'h0, 8'hff); rd(4'h0, v); chk(v, 8'h01 << bp[i]);
			srcs(9'h000, 9'h001 << i, 9'h001 << i); chk(INTERRUPT_PENDING_SUMMARY, 8'h00);
		end
		srcs(9'h01c, 9'h000, 9'h01c); chk(INTERRUPT_PENDING_SUMMARY, 8'h08);
		rd(4'h4, v); chk(v, 8'h07);
		srcs(9'h000, 9'h014, 9'h01c); chk(INTERRUPT_PENDING_SUMMARY, 8'h08);
		rd(4'h4, v); chk(v, 8'h02);
		srcs(9'h000, 9'h008, 9'h01c); chk(INTERRUPT_PENDING_SUMMARY, 8'h00);
		wr(4'h3, 8'h01); wr(4'h1, 8'h10);
		@(posedge CORE_CLK) PERIODIC_WAKEUP_TIMEOUT <= 1'b1;
		@(posedge CORE_CLK) PERIODIC_WAKEUP_TIMEOUT <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		#1 chk(INTERRUPT_PENDING_SUMMARY, 8'h01);
		chk({7'h00, IRQ}, 8'h01);
		rd(4'h1, v); chk(v, 8'h90);
		chk({7'h00, PERIODIC_WAKEUP_FLAG}, 8'h01);
		wr(4'h1, 8'h10); srcs(9'h0, 9'h0, 9'h0); chk(INTERRUPT_PENDING_SUMMARY, 8'h01);
		wr(4'h1, 8'h50); srcs(9'h0, 9'h0, 9'h0); chk(INTERRUPT_PENDING_SUMMARY, 8'h00);
		wr(4'h3, 8'h00); #1 chk({7'h00, IRQ}, 8'h00);
		rd(4'h2, v); chk(v, 8'hff);
		wr(4'h2, 8'hff); rd(4'h2, v); chk(v, 8'h00);
		rd(4'hf, v); chk(v, 8'h00);
		wr(4'h1, 8'h27); rd(4'h1, v); chk(v, 8'h27);
		chk({4'h0, PERIODIC_WAKEUP_CLOCK_SELECT, PERIODIC_WAKEUP_DELAY_SELECT}, 8'h0f);
		srcs(9'h080, 9'h000, 9'h080); chk(INTERRUPT_PENDING_SUMMARY, 8'h40);
		@(posedge CORE_CLK) RST <= 1'b1;
		repeat (4) @(posedge CORE_CLK);
		#1 chk(INTERRUPT_PENDING_SUMMARY, 8'h00);
		results();
	end
endmodule

// File: testbench/ips_pending_summary_props.sv
// Checker for the pending summary: source terms, wakeup acknowledge, reset.
// Assumes it is bound onto ips_pending_summary, everything on CORE_CLK.
`include "ips_defines.svh"
`timescale 1ns/1ps

module ips_pending_props
	import ips_pkg::*;
(
	input logic CORE_CLK,
	input logic RST,
	input logic [3:0] REG_ADDR,
	input logic [7:0] REG_WDATA,
	input logic REG_WR,
	input logic TWO_WIRE_EVENT_FLAG,
	input logic TWO_WIRE_IRQ_ENABLE,
	input logic KEYPAD_EVENT_FLAG,
	input logic KEYPAD_IRQ_ENABLE,
	input logic COMPARATOR_EVENT_FLAG,
	input logic COMPARATOR_IRQ_ENABLE,
	input logic OVERFLOW_FLAG,
	input logic OVERFLOW_IRQ_ENABLE,
	input logic CHANNEL0_EVENT_FLAG,
	input logic CHANNEL0_IRQ_ENABLE,
	input logic CHANNEL1_EVENT_FLAG,
	input logic CHANNEL1_IRQ_ENABLE,
	input logic PERIODIC_WAKEUP_TIMEOUT,
	input logic PERIODIC_WAKEUP_FLAG,
	input logic PERIODIC_WAKEUP_IRQ_ENABLE,
	input logic [7:0] INTERRUPT_PENDING_SUMMARY
);
	logic [4:0] t;
	logic [7:0] s;
	logic ack;
	assign s = INTERRUPT_PENDING_SUMMARY;
	assign t[4] = TWO_WIRE_EVENT_FLAG & TWO_WIRE_IRQ_ENABLE;
	assign t[3] = KEYPAD_EVENT_FLAG & KEYPAD_IRQ_ENABLE;
	assign t[2] = COMPARATOR_EVENT_FLAG & COMPARATOR_IRQ_ENABLE;
	assign t[1] = OVERFLOW_FLAG & OVERFLOW_IRQ_ENABLE | CHANNEL0_EVENT_FLAG & CHANNEL0_IRQ_ENABLE
		| CHANNEL1_EVENT_FLAG & CHANNEL1_IRQ_ENABLE;
	assign t[0] = PERIODIC_WAKEUP_FLAG & PERIODIC_WAKEUP_IRQ_ENABLE;
	assign ack = REG_WR && REG_ADDR == `IPS_OFS_WAKEUP_CTRL;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// Summary is one cycle behind its term; skip the edge right after reset
	property p_bit(logic b, logic x);
		!$past(RST) |-> b == $past(x);
	endproperty
	a_two_wire_bit: assert property (p_bit(s[7], t[4])) else $error("two-wire bit");
	a_keypad_bit: assert property (p_bit(s[6], t[3])) else $error("keypad bit");
	a_comparator_bit: assert property (p_bit(s[5], t[2])) else $error("comparator bit");
	a_timer_or_bit: assert property (p_bit(s[3], t[1])) else $error("timer bit");
	a_wakeup_bit: assert property (p_bit(s[0], t[0])) else $error("wakeup bit");
	a_reset_clear: assert property (disable iff (1'b0) RST |=> s == 8'h00)
		else $error("summary not cleared by reset");
	a_ack_clears: assert property (
		ack && REG_WDATA[`IPS_WK_ACK_BIT] && !PERIODIC_WAKEUP_TIMEOUT |=> !PERIODIC_WAKEUP_FLAG)
		else $error("acknowledge left flag set");
	a_zero_ack_kept: assert property (
		ack && !REG_WDATA[`IPS_WK_ACK_BIT] && PERIODIC_WAKEUP_FLAG |=> PERIODIC_WAKEUP_FLAG)
		else $error("zero acknowledge cleared flag");
	c_timer: cover property (s[3]);
	c_wakeup: cover property (s[0] ##1 !s[0]);
	c_keypad: cover property (s[6]);
endmodule

bind ips_pending_summary ips_pending_props u_props (.*);

// File: testbench/ips_source_model.sv
// Peripheral sources: sticky event flags and held enables, nine pairs.
// Assumes set/clear arrive as one-cycle pulses on CORE_CLK.
`timescale 1ns/1ps

module ips_source_model
	import ips_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [8:0] set_ev,
	input wire logic [8:0] clr_ev,
	input wire logic [8:0] src_en,
	output logic [8:0] flag,
	output logic [8:0] ena
);
	// An event beats a clear in the same cycle, like a real flag
	always_ff @(posedge CORE_CLK) begin
		flag <= RST ? 9'h000 : (flag & ~clr_ev) | set_ev;
	end
	assign ena = src_en;
endmodule
